/* File: tro_defines.svh */
`ifndef TRO_DEFINES_SVH
`define TRO_DEFINES_SVH

// Control register offsets on the control port.
`define TRO_ADDR_TONE1_CTRL   8'h20
`define TRO_ADDR_TONE2_CTRL   8'h21
`define TRO_ADDR_RING_CTRL    8'h22

// Cadence timer bytes: tone 1 on lo/hi, off lo/hi, then tone 2 the same.
`define TRO_ADDR_TONE_TMR_LO  8'h24
`define TRO_ADDR_TONE_TMR_HI  8'h2B
// Ringing on lo/hi, off lo/hi.
`define TRO_ADDR_RING_TMR_LO  8'h30
`define TRO_ADDR_RING_TMR_HI  8'h33

// Field positions inside the control registers.
`define TRO_BIT_ACTIVE        7
`define TRO_BIT_RELOAD        6
`define TRO_BIT_ZERO_CROSS    5
`define TRO_BIT_ON_LINE       5
`define TRO_BIT_ON_TMR_EN     4
`define TRO_BIT_OFF_TMR_EN    3
`define TRO_BIT_OSC_EN        2
`define TRO_BIT_DC_OFFSET     1
`define TRO_BIT_SHAPE         0
`define TRO_PATH_TX           0
`define TRO_PATH_RX           1

// Reset values.
`define TRO_CTRL_RST          8'h00
`define TRO_TMR_RST           16'h0000

// Cadence timer step and the clock rate it is counted from.
`define TRO_TICK_NS           125000
`define TRO_CLK_PERIOD_NS     25
`define TRO_TICK_CYCLES       (`TRO_TICK_NS / `TRO_CLK_PERIOD_NS)

`endif

/* File: tro_pkg.sv */
package tro_pkg;

  typedef enum logic [2:0] {
    TRO_IDLE  = 3'b000,
    TRO_ON    = 3'b001,
    TRO_ZWAIT = 3'b011,
    TRO_OFF   = 3'b010,
    TRO_DONE  = 3'b110
  } tro_state_e;

  typedef struct packed {
    logic        osc_en;
    logic        on_tmr_en;
    logic        off_tmr_en;
    logic        zero_cross_stop;
    logic        auto_reload;
    logic [15:0] on_len;
    logic [15:0] off_len;
  } tro_osc_cfg_s;

endpackage : tro_pkg

/* File: tro_control.sv */
`timescale 1ns/1ps
`include "tro_defines.svh"

module tro_cadence (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  tick_i,
  input  wire tro_pkg::tro_osc_cfg_s cfg_i,
  input  wire logic                  zero_cross_i,
  output logic                       active_o
);
  import tro_pkg::*;

  tro_state_e  state_q;
  tro_state_e  state_d;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic        on_done;
  logic        off_done;

  // A programmed length of zero behaves as one step so a period is never skipped.
  assign on_done  = tick_i && ({1'b0, count_q} + 17'h00001 >= {1'b0, cfg_i.on_len});
  assign off_done = tick_i && ({1'b0, count_q} + 17'h00001 >= {1'b0, cfg_i.off_len});

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    if (tick_i) begin
      count_d = count_q + 16'h0001;
    end
    case (state_q)
      TRO_IDLE: begin
        count_d = 16'h0000;
        if (cfg_i.osc_en) begin
          state_d = TRO_ON;
        end
      end
      TRO_ON: begin
        // Without the on timer the signal stays up until the oscillator is disabled.
        if (cfg_i.on_tmr_en && on_done) begin
          count_d = 16'h0000;
          state_d = cfg_i.zero_cross_stop ? TRO_ZWAIT : TRO_OFF;
        end
      end
      TRO_ZWAIT: begin
        count_d = 16'h0000;
        if (zero_cross_i) begin
          state_d = TRO_OFF;
        end
      end
      TRO_OFF: begin
        if (!cfg_i.off_tmr_en) begin
          state_d = TRO_DONE;
        end else if (off_done) begin
          count_d = 16'h0000;
          state_d = cfg_i.auto_reload ? TRO_ON : TRO_DONE;
        end
      end
      TRO_DONE: begin
        count_d = 16'h0000;
      end
      default: begin
        state_d = TRO_IDLE;
        count_d = 16'h0000;
      end
    endcase
    if (!cfg_i.osc_en) begin
      state_d = TRO_IDLE;
      count_d = 16'h0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= TRO_IDLE;
      count_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  assign active_o = (state_q == TRO_ON) || (state_q == TRO_ZWAIT);

endmodule : tro_cadence

module tro_control #(
  parameter int unsigned TICK_CYCLES = `TRO_TICK_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_rvalid_o,
  input  wire logic       tone1_zero_cross_i,
  input  wire logic       tone2_zero_cross_i,
  input  wire logic       ring_enable_i,
  input  wire logic       ring_dc_cross_i,
  output logic            tone1_tx_o,
  output logic            tone1_rx_o,
  output logic            tone1_auto_reload_o,
  output logic            tone2_tx_o,
  output logic            tone2_rx_o,
  output logic            ring_active_o,
  output logic            ring_drive_o,
  output logic            ring_dc_offset_en_o,
  output logic            ring_shape_select_o
);
  import tro_pkg::*;

  localparam int unsigned NUM_TMR = 6;

  logic [7:0]  tone1_ctrl_q;
  logic [7:0]  tone1_ctrl_d;
  logic [7:0]  tone2_ctrl_q;
  logic [7:0]  tone2_ctrl_d;
  logic [7:0]  ring_ctrl_q;
  logic [7:0]  ring_ctrl_d;
  logic [15:0] tmr_q [NUM_TMR];
  logic [15:0] tmr_d [NUM_TMR];
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;
  logic        rvalid_q;
  logic        ring_en_q;
  logic        ring_drive_q;
  logic        ring_drive_d;
  logic [5:0]  out_q;
  logic [5:0]  out_d;
  logic [12:0] presc_q;
  logic [12:0] presc_d;
  logic        tick;
  logic        tone1_act;
  logic        tone2_act;
  logic        ring_act;
  logic        tmr_sel;
  logic [2:0]  tmr_idx;
  logic        tmr_hi;
  logic [7:0]  tmr_off;
  logic [7:0]  ring_off;
  tro_osc_cfg_s tone1_cfg;
  tro_osc_cfg_s tone2_cfg;
  tro_osc_cfg_s ring_cfg;

  // Free-running step counter shared by all cadence timers.
  assign tick = (presc_q == 13'(TICK_CYCLES - 1));

  always_comb begin
    presc_d = tick ? 13'h0000 : presc_q + 13'h0001;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_q <= 13'h0000;
    end else begin
      presc_q <= presc_d;
    end
  end

  // Timer byte decode: two bytes per 16-bit timer, low byte first.
  assign tmr_off  = reg_addr_i - `TRO_ADDR_TONE_TMR_LO;
  assign ring_off = reg_addr_i - `TRO_ADDR_RING_TMR_LO;

  always_comb begin
    tmr_sel = 1'b0;
    tmr_idx = 3'h0;
    tmr_hi  = 1'b0;
    if (reg_addr_i >= `TRO_ADDR_TONE_TMR_LO && reg_addr_i <= `TRO_ADDR_TONE_TMR_HI) begin
      tmr_sel = 1'b1;
      tmr_idx = tmr_off[3:1];
      tmr_hi  = tmr_off[0];
    end else if (reg_addr_i >= `TRO_ADDR_RING_TMR_LO
                 && reg_addr_i <= `TRO_ADDR_RING_TMR_HI) begin
      tmr_sel = 1'b1;
      tmr_idx = 3'h4 + {2'h0, ring_off[1]};
      tmr_hi  = ring_off[0];
    end
  end

  // Control writes keep only the writable fields; status and reserved bits stay zero.
  always_comb begin
    tone1_ctrl_d = tone1_ctrl_q;
    tone2_ctrl_d = tone2_ctrl_q;
    ring_ctrl_d  = ring_ctrl_q;
    for (int i = 0; i < NUM_TMR; i++) begin
      tmr_d[i] = tmr_q[i];
    end
    if (reg_wr_i) begin
      case (reg_addr_i)
        `TRO_ADDR_TONE1_CTRL: tone1_ctrl_d = reg_wdata_i & 8'h7F;
        `TRO_ADDR_TONE2_CTRL: tone2_ctrl_d = reg_wdata_i & 8'h3F;
        `TRO_ADDR_RING_CTRL:  ring_ctrl_d  = reg_wdata_i & 8'h1B;
        default: begin
          if (tmr_sel) begin
            if (tmr_hi) begin
              tmr_d[tmr_idx] = {reg_wdata_i, tmr_q[tmr_idx][7:0]};
            end else begin
              tmr_d[tmr_idx] = {tmr_q[tmr_idx][15:8], reg_wdata_i};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tone1_ctrl_q <= `TRO_CTRL_RST;
      tone2_ctrl_q <= `TRO_CTRL_RST;
      ring_ctrl_q  <= `TRO_CTRL_RST;
      for (int i = 0; i < NUM_TMR; i++) begin
        tmr_q[i] <= `TRO_TMR_RST;
      end
    end else begin
      tone1_ctrl_q <= tone1_ctrl_d;
      tone2_ctrl_q <= tone2_ctrl_d;
      ring_ctrl_q  <= ring_ctrl_d;
      for (int i = 0; i < NUM_TMR; i++) begin
        tmr_q[i] <= tmr_d[i];
      end
    end
  end

  // Software is expected to hold reload set for FSK so the parameters keep streaming.
  assign tone1_cfg = '{osc_en:          tone1_ctrl_q[`TRO_BIT_OSC_EN],
                       on_tmr_en:       tone1_ctrl_q[`TRO_BIT_ON_TMR_EN],
                       off_tmr_en:      tone1_ctrl_q[`TRO_BIT_OFF_TMR_EN],
                       zero_cross_stop: tone1_ctrl_q[`TRO_BIT_ZERO_CROSS],
                       auto_reload:     tone1_ctrl_q[`TRO_BIT_RELOAD],
                       on_len:          tmr_q[0],
                       off_len:         tmr_q[1]};
  // Tone 2 and ringing have no reload control and simply keep cadencing.
  assign tone2_cfg = '{osc_en:          tone2_ctrl_q[`TRO_BIT_OSC_EN],
                       on_tmr_en:       tone2_ctrl_q[`TRO_BIT_ON_TMR_EN],
                       off_tmr_en:      tone2_ctrl_q[`TRO_BIT_OFF_TMR_EN],
                       zero_cross_stop: tone2_ctrl_q[`TRO_BIT_ZERO_CROSS],
                       auto_reload:     1'b1,
                       on_len:          tmr_q[2],
                       off_len:         tmr_q[3]};
  assign ring_cfg  = '{osc_en:          ring_en_q,
                       on_tmr_en:       ring_ctrl_q[`TRO_BIT_ON_TMR_EN],
                       off_tmr_en:      ring_ctrl_q[`TRO_BIT_OFF_TMR_EN],
                       zero_cross_stop: 1'b0,
                       auto_reload:     1'b1,
                       on_len:          tmr_q[4],
                       off_len:         tmr_q[5]};

  tro_cadence u_tone1 (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .tick_i       (tick),
    .cfg_i        (tone1_cfg),
    .zero_cross_i (tone1_zero_cross_i),
    .active_o     (tone1_act)
  );

  tro_cadence u_tone2 (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .tick_i       (tick),
    .cfg_i        (tone2_cfg),
    .zero_cross_i (tone2_zero_cross_i),
    .active_o     (tone2_act)
  );

  tro_cadence u_ring (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .tick_i       (tick),
    .cfg_i        (ring_cfg),
    .zero_cross_i (1'b0),
    .active_o     (ring_act)
  );

  // The line only follows the ringing state at a dc crossing, so no step hits the pair.
  always_comb begin
    ring_drive_d = ring_drive_q;
    if (ring_dc_cross_i && (ring_act != ring_drive_q)) begin
      ring_drive_d = ring_act;
    end
  end

  always_comb begin
    out_d[0] = tone1_act && tone1_ctrl_q[`TRO_PATH_TX];
    out_d[1] = tone1_act && tone1_ctrl_q[`TRO_PATH_RX];
    out_d[2] = tone2_act && tone2_ctrl_q[`TRO_PATH_TX];
    out_d[3] = tone2_act && tone2_ctrl_q[`TRO_PATH_RX];
    out_d[4] = ring_ctrl_q[`TRO_BIT_DC_OFFSET];
    out_d[5] = ring_ctrl_q[`TRO_BIT_SHAPE];
  end

  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr_i)
      `TRO_ADDR_TONE1_CTRL: rdata_d = {tone1_act, tone1_ctrl_q[6:0]};
      `TRO_ADDR_TONE2_CTRL: rdata_d = {tone2_act, 1'b0, tone2_ctrl_q[5:0]};
      `TRO_ADDR_RING_CTRL:  rdata_d = {ring_act, 1'b0, ring_drive_q,
                                       ring_ctrl_q[4:3], ring_en_q,
                                       ring_ctrl_q[1:0]};
      default: begin
        if (tmr_sel) begin
          rdata_d = tmr_hi ? tmr_q[tmr_idx][15:8] : tmr_q[tmr_idx][7:0];
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q      <= 8'h00;
      rvalid_q     <= 1'b0;
      ring_en_q    <= 1'b0;
      ring_drive_q <= 1'b0;
      out_q        <= 6'h00;
    end else begin
      rdata_q      <= reg_rd_i ? rdata_d : rdata_q;
      rvalid_q     <= reg_rd_i;
      ring_en_q    <= ring_enable_i;
      ring_drive_q <= ring_drive_d;
      out_q        <= out_d;
    end
  end

  assign reg_rdata_o         = rdata_q;
  assign reg_rvalid_o        = rvalid_q;
  assign tone1_tx_o          = out_q[0];
  assign tone1_rx_o          = out_q[1];
  assign tone2_tx_o          = out_q[2];
  assign tone2_rx_o          = out_q[3];
  assign ring_dc_offset_en_o = out_q[4];
  assign ring_shape_select_o = out_q[5];
  assign tone1_auto_reload_o = tone1_ctrl_q[`TRO_BIT_RELOAD];
  assign ring_active_o       = ring_act;
  assign ring_drive_o        = ring_drive_q;

endmodule : tro_control

/* File: tro_control_end_marker_unused.sv */
`timescale 1ns/1ps

/* File: tro_control_assertions.sv */
`timescale 1ns/1ps
module tro_control_chk #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       reg_rvalid_o,
  input wire logic       ring_enable_i,
  input wire logic       ring_dc_cross_i,
  input wire logic       tone1_tx_o,
  input wire logic       tone1_rx_o,
  input wire logic       tone2_tx_o,
  input wire logic       tone2_rx_o,
  input wire logic       ring_active_o,
  input wire logic       ring_drive_o,
  input wire logic       ring_dc_offset_en_o,
  input wire logic       ring_shape_select_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  a_no_stray_valid: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("read valid without read");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 8'h23 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_reserved_six: assert property (reg_rd_i && reg_addr_i inside {8'h21, 8'h22}
    |=> !reg_rdata_o[6])
    else $error("reserved bit reads one");
  a_ring_status_bits: assert property (reg_rd_i && reg_addr_i == 8'h22
    |=> reg_rdata_o[7] == $past(ring_active_o) && reg_rdata_o[5] == $past(ring_drive_o))
    else $error("ring status bits wrong");
  a_ring_gate_dc: assert property ($changed(ring_drive_o) |-> $past(ring_dc_cross_i))
    else $error("ring drive changed off a dc crossing");
  a_ring_enable_bit: assert property (reg_rd_i && reg_addr_i == 8'h22 && !$past(rst_i)
    && $stable(ring_enable_i) |=> reg_rdata_o[2] == $past(ring_enable_i))
    else $error("ring enable bit wrong");
  a_tone1_path_off: assert property (reg_wr_i && reg_addr_i == 8'h20 && reg_wdata_i[1:0] == 2'b00
    |=> ##1 !tone1_tx_o && !tone1_rx_o)
    else $error("tone 1 routed while unassigned");
  a_tone2_path_off: assert property (reg_wr_i && reg_addr_i == 8'h21 && reg_wdata_i[1:0] == 2'b00
    |=> ##1 !tone2_tx_o && !tone2_rx_o)
    else $error("tone 2 routed while unassigned");
  a_ring_shape_copy: assert property (reg_wr_i && reg_addr_i == 8'h22 |=> ##1
    ring_dc_offset_en_o == $past(reg_wdata_i[1], 2) && ring_shape_select_o == $past(reg_wdata_i[0], 2))
    else $error("ring offset or shape wrong");

  c_tone1_read: cover property (reg_rd_i && reg_addr_i == 8'h20);
  c_tone1_stop: cover property ($fell(tone1_tx_o));
  c_ring_drive: cover property ($rose(ring_drive_o));
endmodule : tro_control_chk

bind tro_control tro_control_chk #(.TICK_CYCLES(TICK_CYCLES)) tro_control_chk_i (
  .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .ring_enable_i(ring_enable_i),
  .ring_dc_cross_i(ring_dc_cross_i), .tone1_tx_o(tone1_tx_o), .tone1_rx_o(tone1_rx_o),
  .tone2_tx_o(tone2_tx_o), .tone2_rx_o(tone2_rx_o), .ring_active_o(ring_active_o),
  .ring_drive_o(ring_drive_o), .ring_dc_offset_en_o(ring_dc_offset_en_o),
  .ring_shape_select_o(ring_shape_select_o));

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic       clk_i, rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic       tone1_zero_cross_i, tone2_zero_cross_i, ring_enable_i, ring_dc_cross_i;
  logic       tone1_tx_o, tone1_rx_o, tone1_auto_reload_o, tone2_tx_o, tone2_rx_o;
  logic       ring_active_o, ring_drive_o, ring_dc_offset_en_o, ring_shape_select_o;
  int         err_total, checked, n;

  tro_control #(.TICK_CYCLES(4)) tro_control_i (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .tone1_zero_cross_i(tone1_zero_cross_i),
    .tone2_zero_cross_i(tone2_zero_cross_i), .ring_enable_i(ring_enable_i),
    .ring_dc_cross_i(ring_dc_cross_i), .tone1_tx_o(tone1_tx_o), .tone1_rx_o(tone1_rx_o),
    .tone1_auto_reload_o(tone1_auto_reload_o), .tone2_tx_o(tone2_tx_o),
    .tone2_rx_o(tone2_rx_o), .ring_active_o(ring_active_o), .ring_drive_o(ring_drive_o),
    .ring_dc_offset_en_o(ring_dc_offset_en_o), .ring_shape_select_o(ring_shape_select_o));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask : cyc

  // The trailing idle cycle lets a write settle before anything looks at it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i  = a;
    reg_wdata_i = d;
    reg_wr_i    = 1'b1;
    cyc(1);
    reg_wr_i = 1'b0;
    cyc(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr_i = a;
    reg_rd_i   = 1'b1;
    cyc(1);
    reg_rd_i = 1'b0;
    chk({7'h00, reg_rvalid_o}, 8'h01);
    chk(reg_rdata_o, e);
    cyc(1);
  endtask : rd

  // Counts cycles until tone 1 transmit reaches the level, bounded by lim.
  task automatic wt(input logic v, input int lim);
    n = 0;
    while (tone1_tx_o !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : wt

  task automatic close_out;
    if (err_total == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  initial begin
    repeat (3000) @(posedge clk_i);
    err_total++;
    close_out();
  end

  initial begin
    {rst_i, reg_wr_i, reg_rd_i, tone1_zero_cross_i, tone2_zero_cross_i} = 5'h10;
    {ring_enable_i, ring_dc_cross_i, reg_addr_i, reg_wdata_i} = 18'h00000;
    err_total = 0;
    checked = 0;
    repeat (16) @(posedge clk_i);
    cyc(1);
    rst_i = 1'b0;
    rd(8'h20, 8'h00);
    rd(8'h21, 8'h00);
    rd(8'h22, 8'h00);
    rd(8'h23, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wr(8'h20, 8'h04 | p[7:0]);
      wr(8'h21, 8'h44 | p[7:0]);
      cyc(2);
      chk({6'h00, tone1_rx_o, tone1_tx_o}, p[7:0]);
      chk({6'h00, tone2_rx_o, tone2_tx_o}, p[7:0]);
      rd(8'h20, 8'h84 | p[7:0]);
      rd(8'h21, 8'h84 | p[7:0]);
    end
    wr(8'h20, 8'h78);
    rd(8'h20, 8'h78);
    wr(8'h21, 8'h7B);
    rd(8'h21, 8'h3B);
    wr(8'h22, 8'hFF);
    rd(8'h22, 8'h1B);
    chk({6'h00, ring_dc_offset_en_o, ring_shape_select_o}, 8'h03);
    wr(8'h22, 8'h01);
    chk({6'h00, ring_dc_offset_en_o, ring_shape_select_o}, 8'h01);
    wr(8'h24, 8'h02);
    wr(8'h26, 8'h03);
    rd(8'h24, 8'h02);
    wr(8'h20, 8'h5D);
    chk({7'h00, tone1_auto_reload_o}, 8'h01);
    // The first on period is cut short by the free prescaler, so it is skipped.
    wt(1'b1, 40);
    wt(1'b0, 40);
    wt(1'b1, 40);
    chk(n[7:0], 8'h0C);
    wt(1'b0, 40);
    chk(n[7:0], 8'h08);
    wr(8'h20, 8'h1D);
    wt(1'b0, 40);
    wt(1'b1, 60);
    chk({7'h00, tone1_tx_o}, 8'h00);
    rd(8'h20, 8'h1D);
    wr(8'h20, 8'h00);
    wr(8'h20, 8'h35);
    cyc(40);
    chk({7'h00, tone1_tx_o}, 8'h01);
    tone1_zero_cross_i = 1'b1;
    cyc(1);
    tone1_zero_cross_i = 1'b0;
    wt(1'b0, 4);
    chk({7'h00, tone1_tx_o}, 8'h00);
    wr(8'h2B, 8'h5A);
    rd(8'h2B, 8'h5A);
    wr(8'h21, 8'h35);
    cyc(20);
    chk({7'h00, tone2_tx_o}, 8'h01);
    tone2_zero_cross_i = 1'b1;
    cyc(1);
    tone2_zero_cross_i = 1'b0;
    cyc(2);
    chk({7'h00, tone2_tx_o}, 8'h00);
    ring_enable_i = 1'b1;
    wr(8'h30, 8'h40);
    wr(8'h32, 8'h01);
    rd(8'h30, 8'h40);
    wr(8'h22, 8'h18);
    rd(8'h22, 8'h9C);
    chk({ring_active_o, ring_drive_o}, 8'h02);
    ring_dc_cross_i = 1'b1;
    cyc(1);
    ring_dc_cross_i = 1'b0;
    cyc(1);
    rd(8'h22, 8'hBC);
    ring_enable_i = 1'b0;
    cyc(4);
    chk({ring_active_o, ring_drive_o}, 8'h01);
    ring_dc_cross_i = 1'b1;
    cyc(1);
    ring_dc_cross_i = 1'b0;
    cyc(1);
    chk({7'h00, ring_drive_o}, 8'h00);
    close_out();
  end
endmodule : testbench
